// ===== tb/seeb_master_model.sv
// far-side two-wire bus master model
`timescale 1ns/1ps
module seeb_master_model (
  // clock
  input wire logic core_clk,
  // bus, sda released reads as pulled-up one
  input wire logic sdaLine,
  output logic scl,
  output logic sdaLow
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // ****************
  // bus actions
  // ****************
  task automatic q();
    repeat (2) @(posedge core_clk);
  endtask
  // also a restart; scl stands high and still between frames
  task automatic start();
    sdaLow <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sdaLow <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic stop();
    sdaLow <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sdaLow <= 1'b0;
    q();
  endtask
  // late sample in the high phase leaves room for the slave's synchroniser
  task automatic bitX(input logic b, output logic s);
    sdaLow <= ~b;
    q();
    scl <= 1'b1;
    q();
    @(posedge core_clk);
    @(negedge core_clk);
    s = sdaLine;
    @(posedge core_clk);
    scl <= 1'b0;
    q();
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitX(d[i], s);
    end
    bitX(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv(input logic ackIt, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitX(1'b1, s);
      d[i] = s;
    end
    bitX(~ackIt, s);
  endtask
endmodule

// ===== tb/seeb_slave_tb.sv
// testbench of the serial eeprom bus slave
`timescale 1ns/1ps
module seeb_slave_tb;
  import seeb_pkg::*;
  localparam int WCYC = 200;
  localparam logic [6:0] SA = {SEEB_TYPE_CODE, 3'h5};
  localparam logic [6:0] SB = SA ^ 7'h01;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic wp = 1'b0;
  logic wrReady = 1'b0;
  logic [2:0] pins = 3'h5;
  logic sdaOut, sdaOen, wrValid, busy, scl, sdaLow, sdaLine;
  logic [SEEB_ADDR_BITS-1:0] rdAddr;
  logic [SEEB_BYTE_BITS-1:0] rdData;
  seeb_word_s wrWord;
  int miscompares = 0;
  int check_count = 0;
  assign sdaLine = ~sdaLow & (sdaOen | sdaOut);
  // arbitrary array contents, easy to predict
  assign rdData = rdAddr[7:0] ^ 8'h5a;
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  seeb_slave #(.ADDR_HIGH_BITS(1), .WRITE_CYCLES(WCYC)) seeb_slave_i (
    .core_clk(core_clk), .rstn(rstn), .sclIn(scl), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOen(sdaOen), .chip_sel_pin0(pins[0]),
    .chip_sel_pin1(pins[1]), .chip_sel_pin2(pins[2]), .write_protect_input(wp),
    .rdData(rdData), .rdAddr(rdAddr), .wrValid(wrValid), .wrReady(wrReady),
    .wrWord(wrWord), .busy(busy)
  );
  seeb_master_model seeb_master_model_i (
    .core_clk(core_clk), .sdaLine(sdaLine), .scl(scl), .sdaLow(sdaLow)
  );
  task automatic checkBit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic checkVal(input logic [18:0] got, input logic [18:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_select();
    logic a;
    seeb_master_model_i.start();
    seeb_master_model_i.send({SA ^ 7'h40, 1'b0}, a);
    checkBit(a, 1'b0);
    seeb_master_model_i.send({SA, 1'b0}, a);
    checkBit(a, 1'b0);
    seeb_master_model_i.start();
    seeb_master_model_i.send({SA ^ 7'h02, 1'b0}, a);
    checkBit(a, 1'b0);
    seeb_master_model_i.start();
    for (int i = 0; i < 4; i++) begin
      seeb_master_model_i.bitX(1'b0, a);
    end
    seeb_master_model_i.start();
    seeb_master_model_i.send({SB, 1'b0}, a);
    checkBit(a, 1'b1);
    seeb_master_model_i.stop();
  endtask
  task automatic t_page();
    logic a;
    int n;
    seeb_master_model_i.start();
    seeb_master_model_i.send({SA, 1'b0}, a);
    checkBit(a, 1'b1);
    seeb_master_model_i.send(8'h0e, a);
    checkBit(a, 1'b1);
    for (int i = 0; i < 4; i++) begin
      seeb_master_model_i.send(8'hc0 + 8'(i), a);
      checkBit(a, 1'b1);
    end
    seeb_master_model_i.stop();
    repeat (6) @(posedge core_clk);
    checkBit(busy, 1'b1);
    n = 0;
    a = 1'b0;
    while (a !== 1'b1 && n < 8) begin
      seeb_master_model_i.start();
      seeb_master_model_i.send({SA, 1'b0}, a);
      n++;
    end
    checkBit(n > 1 && a === 1'b1, 1'b1);
    seeb_master_model_i.stop();
    // the sink stalled through the whole page, now it drains
    wrReady <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      n = 0;
      @(negedge core_clk);
      while (wrValid !== 1'b1 && n < 16) begin
        @(negedge core_clk);
        n++;
      end
      checkBit(wrValid, 1'b1);
      checkVal(wrWord, {3'h1, 4'h0, 4'((14 + i) % 16), 8'hc0 + 8'(i)});
      @(posedge core_clk);
    end
    wrReady <= 1'b0;
    checkBit(busy, 1'b0);
  endtask
  task automatic t_protect();
    logic a;
    wp <= 1'b1;
    seeb_master_model_i.start();
    seeb_master_model_i.send({SB, 1'b0}, a);
    checkBit(a, 1'b1);
    seeb_master_model_i.send(8'h21, a);
    checkBit(a, 1'b1);
    seeb_master_model_i.send(8'h77, a);
    checkBit(a, 1'b0);
    seeb_master_model_i.stop();
    repeat (6) @(posedge core_clk);
    checkBit(wrValid, 1'b0);
    checkBit(busy, 1'b0);
  endtask
  task automatic t_read();
    logic a;
    logic [7:0] d;
    seeb_master_model_i.start();
    seeb_master_model_i.send({SA, 1'b0}, a);
    seeb_master_model_i.send(8'h33, a);
    checkBit(a, 1'b1);
    seeb_master_model_i.start();
    seeb_master_model_i.send({SA, 1'b1}, a);
    checkBit(a, 1'b1);
    seeb_master_model_i.recv(1'b0, d);
    checkVal(19'(d), 19'(8'h33 ^ 8'h5a));
    seeb_master_model_i.send({SA, 1'b1}, a);
    checkBit(a, 1'b0);
    seeb_master_model_i.stop();
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_select();
    t_page();
    t_protect();
    t_read();
    give_verdict();
  end
  initial begin
    repeat (90000) @(posedge core_clk);
    miscompares++;
    give_verdict();
  end
endmodule

// ===== verilog/seeb_fifo.sv
// small synchronous fifo for accepted write bytes
`timescale 1ns/1ps
module seeb_fifo
  import seeb_pkg::*;
#(
  parameter int WIDTH = 19,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
  } seeb_fifo_s;
  seeb_fifo_s st, next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full, empty;

  assign empty = (st.wrPtr == st.rdPtr);
  assign full = (st.wrPtr[AW] != st.rdPtr[AW]) && (st.wrPtr[AW-1:0] == st.rdPtr[AW-1:0]);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[st.rdPtr[AW-1:0]];

  always_comb begin
    next_st = st;
    if (inValid && !full) begin
      next_st.wrPtr = st.wrPtr + 1'b1;
    end
    if (outReady && !empty) begin
      next_st.rdPtr = st.rdPtr + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge core_clk) begin
    if (inValid && !full) begin
      mem[st.wrPtr[AW-1:0]] <= inData;
    end
  end
endmodule

// ===== verilog/seeb_pkg.sv
// shared constants and carriers of the serial eeprom bus slave
package seeb_pkg;
  localparam logic [3:0] SEEB_TYPE_CODE = 4'h5; // arbitrary memory-type code
  localparam int SEEB_BYTE_BITS = 8;
  localparam int SEEB_PAGE_BITS = 4;
  localparam int SEEB_ADDR_BITS = 11;
  localparam int SEEB_FIFO_DEPTH = 8;
  localparam int SEEB_CLK_HZ = 40000000;
  // write cycle time in microseconds
  localparam int SEEB_WRITE_CYCLE_US = 10;
  localparam int SEEB_WRITE_CYCLES = SEEB_WRITE_CYCLE_US * (SEEB_CLK_HZ / 1000000);
  localparam logic [3:0] SEEB_ACK_SLOT = 4'h8;
  localparam logic [3:0] SEEB_CNT_RESET = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SELECT, ST_ADDR, ST_WDATA, ST_RDATA, ST_BUSY
  } seeb_state_e;

  // one received byte and where it lands
  typedef struct packed {
    logic [SEEB_ADDR_BITS-1:0] addr;
    logic [SEEB_BYTE_BITS-1:0] data;
  } seeb_word_s;
endpackage

// ===== verilog/seeb_slave.sv
// protocol engine of the serial eeprom two-wire bus slave
//
// Behaviour
// R1: start, then select byte msb first
// R2: type field must equal memory-type code
// R3: chip-enable field must match chip-enable pins
// R4: larger parts take those bits as address
// R5: eighth bit one reads, zero writes
// R6: matching select byte acked in ninth bit
// R7: mismatch releases sda, standby until start
// R8: write select, address byte, both acked
// R9: protect high before address end blocks data
// R10: protected data nacked, else acked
// R11: page write up to 16, row wraps
// R12: only low four address bits increment
// R13: write cycle only on stop after data ack
// R14: busy cycle ignores bus, no ack
// R15: master polls select byte until acked
// R16: reads ignore write protect
// R17: random read via dummy write, restart
// R18: master repeats upper seven select bits
// R19: sda sampled on scl rising edge
// R20: protect still acks select and address
// R21: read nack ends transfer, standby
// R22: start and stop abort byte anywhere
// R23: write cycle is bounded configurable interval
`timescale 1ns/1ps
module seeb_slave
  import seeb_pkg::*;
#(
  parameter int ADDR_HIGH_BITS = 3,
  parameter int WRITE_CYCLES = SEEB_WRITE_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // two-wire bus, sda open drain
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOen,
  // straps
  input wire logic chip_sel_pin0,
  input wire logic chip_sel_pin1,
  input wire logic chip_sel_pin2,
  input wire logic write_protect_input,
  // read data for the current address, from the array
  input wire logic [SEEB_BYTE_BITS-1:0] rdData,
  output logic [SEEB_ADDR_BITS-1:0] rdAddr,
  // accepted write bytes towards the array
  output logic wrValid,
  input wire logic wrReady,
  output seeb_word_s wrWord,
  // status
  output logic busy
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [1:0] sclSync;
    logic [1:0] sdaSync;
    logic [1:0] wpSync;
    logic [2:0] pinSync0;
    logic [2:0] pinSync1;
    logic sclPrev;
    logic sdaPrev;
    seeb_state_e state;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic ackPhase;
    logic driveLow;
    logic readDir;
    logic protect;
    logic dataAcked;
    logic masterAck;
    logic [SEEB_ADDR_BITS-1:0] addr;
    logic [31:0] busyCnt;
    logic pushReq;
    seeb_word_s pushWord;
  } seeb_slave_s;
  seeb_slave_s st, next_st;

  logic scl, sda, sclRise, sclFall, startCond, stopCond;
  logic fifoReady;
  logic [2:0] pins, ceMask;
  logic wp;

  assign scl = st.sclSync[1];
  assign sda = st.sdaSync[1];
  assign sclRise = scl && !st.sclPrev;
  assign sclFall = !scl && st.sclPrev;
  assign startCond = scl && st.sclPrev && st.sdaPrev && !sda;
  assign stopCond = scl && st.sclPrev && !st.sdaPrev && sda;
  // straps and protect are pins too, read only after two flops
  assign pins = st.pinSync1;
  assign wp = st.wpSync[1];
  // low positions replaced by address bits on large parts
  assign ceMask = 3'h7 << ADDR_HIGH_BITS; // see R4

  function automatic logic selMatch(input logic [7:0] b, input logic [2:0] p,
                                    input logic [2:0] m);
    selMatch = (b[7:4] == SEEB_TYPE_CODE) && ((b[3:1] & m) == (p & m));
  endfunction

  assign sdaOut = 1'b0;
  assign sdaOen = !st.driveLow;
  assign rdAddr = st.addr;
  assign busy = (st.state == ST_BUSY);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.sclSync = {st.sclSync[0], sclIn};
    next_st.sdaSync = {st.sdaSync[0], sdaIn};
    next_st.wpSync = {st.wpSync[0], write_protect_input};
    next_st.pinSync0 = {chip_sel_pin2, chip_sel_pin1, chip_sel_pin0};
    next_st.pinSync1 = st.pinSync0;
    next_st.sclPrev = scl;
    next_st.sdaPrev = sda;
    if (st.pushReq && fifoReady) begin
      next_st.pushReq = 1'b0;
    end
    if (wp && (st.state == ST_SELECT || st.state == ST_ADDR)) begin
      next_st.protect = 1'b1; // see R9
    end
    case (st.state)
      ST_BUSY: begin
        // bus ignored entirely while the cycle runs
        next_st.driveLow = 1'b0; // see R14
        if (st.busyCnt >= 32'(WRITE_CYCLES - 1)) begin
          next_st.state = ST_IDLE; // see R23
          next_st.busyCnt = '0;
        end else begin
          next_st.busyCnt = st.busyCnt + 32'd1;
        end
      end
      default: begin
        if (startCond) begin
          // restart keeps the loaded address for the random read
          next_st.state = ST_SELECT; // see R22
          next_st.bitCnt = SEEB_CNT_RESET;
          next_st.ackPhase = 1'b0;
          next_st.driveLow = 1'b0;
          next_st.dataAcked = 1'b0;
          next_st.protect = wp;
        end else if (stopCond) begin
          next_st.driveLow = 1'b0;
          next_st.bitCnt = SEEB_CNT_RESET;
          next_st.ackPhase = 1'b0;
          // only a stop right after a data ack starts the cycle
          // the rise of the stop slot has already counted one bit
          if (st.state == ST_WDATA && st.dataAcked && st.bitCnt == SEEB_CNT_RESET + 4'h1) begin
            next_st.state = ST_BUSY; // see R13
          end else begin
            next_st.state = ST_IDLE; // see R22
          end
        end else if (st.state != ST_IDLE) begin
          if (sclRise && !st.ackPhase) begin
            next_st.shift = {st.shift[6:0], sda}; // see R1 R19
            next_st.bitCnt = st.bitCnt + 4'h1;
            // the ack flag must survive the first rise of the stop slot
            next_st.dataAcked = st.dataAcked && (st.bitCnt == SEEB_CNT_RESET);
          end else if (sclRise && st.ackPhase) begin
            next_st.masterAck = !sda; // see R21
          end
          if (sclFall && !st.ackPhase && st.bitCnt == SEEB_ACK_SLOT) begin
            next_st.ackPhase = 1'b1;
            next_st.bitCnt = SEEB_CNT_RESET;
            case (st.state)
              ST_SELECT: begin
                if (selMatch(st.shift, pins, ceMask)) begin // see R2 R3
                  next_st.driveLow = 1'b1; // see R6 R20
                  next_st.readDir = st.shift[0]; // see R5
                  for (int i = 0; i < ADDR_HIGH_BITS; i++) begin
                    next_st.addr[8 + i] = st.shift[1 + i]; // see R4
                  end
                end else begin
                  next_st.state = ST_IDLE; // see R7
                  next_st.ackPhase = 1'b0;
                end
              end
              ST_ADDR: begin
                next_st.addr[7:0] = st.shift; // see R8 R17
                next_st.driveLow = 1'b1; // see R20
              end
              ST_WDATA: begin
                if (!st.protect) begin
                  next_st.driveLow = 1'b1; // see R10
                  next_st.pushReq = 1'b1;
                  next_st.pushWord = '{addr: st.addr, data: st.shift};
                end
              end
              ST_RDATA: begin
                // let go of sda for the master's ack slot
                next_st.driveLow = 1'b0; // see R21
              end
              default: begin
              end
            endcase
          end else if (sclFall && st.ackPhase) begin
            next_st.ackPhase = 1'b0;
            next_st.driveLow = 1'b0;
            case (st.state)
              ST_SELECT: begin
                // reads go on whatever the protect level
                next_st.state = st.readDir ? ST_RDATA : ST_ADDR; // see R16
                next_st.driveLow = st.readDir && !rdData[7];
                next_st.shift = rdData;
                next_st.bitCnt = st.readDir ? 4'h1 : SEEB_CNT_RESET;
              end
              ST_ADDR: begin
                next_st.state = ST_WDATA; // see R8
              end
              ST_WDATA: begin
                next_st.dataAcked = st.driveLow;
                if (st.driveLow) begin
                  next_st.addr[3:0] = st.addr[3:0] + 4'h1; // see R11 R12
                end
              end
              ST_RDATA: begin
                if (!st.masterAck) begin
                  next_st.state = ST_IDLE; // see R21
                end else begin
                  next_st.addr = st.addr + 1'b1;
                  next_st.state = ST_IDLE;
                end
              end
              default: begin
              end
            endcase
          end else if (sclFall && st.state == ST_RDATA && !st.ackPhase) begin
            // shift out the next bit; release before the master ack slot
            if (st.bitCnt == SEEB_ACK_SLOT) begin
              next_st.driveLow = 1'b0;
            end else begin
              next_st.driveLow = !st.shift[7 - st.bitCnt[2:0]];
              next_st.bitCnt = st.bitCnt + 4'h1;
            end
          end
          // the slave drives read bits, so its own rises shift nothing in
          if (st.state == ST_RDATA && sclRise) begin
            next_st.shift = st.shift;
            next_st.bitCnt = st.bitCnt;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '{sclSync: 2'h3, sdaSync: 2'h3, sclPrev: 1'b1, sdaPrev: 1'b1,
              state: ST_IDLE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // write byte buffer
  // ****************************************
  // fifo stall: the push waits, but a next byte acked while it still waits overwrites it; array drain is far faster than scl
  seeb_fifo #(.WIDTH($bits(seeb_word_s)), .DEPTH(SEEB_FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .inValid(st.pushReq),
    .inReady(fifoReady),
    .inData(st.pushWord),
    .outValid(wrValid),
    .outReady(wrReady),
    .outData(wrWord)
  );

  // ****************************************
  // checks
  // ****************************************
  a_busy_silent: assert property (@(posedge core_clk) disable iff (!rstn) // see R14
    busy |-> sdaOen) else $error("sda driven during write cycle");
  a_busy_bound: assert property (@(posedge core_clk) disable iff (!rstn) // see R23
    $rose(busy) |-> busy [*8]) else $error("write cycle ended too soon");
  a_stop_cycle: assert property (@(posedge core_clk) disable iff (!rstn) // see R13
    $rose(busy) |-> $past(st.state) == ST_WDATA && $past(st.dataAcked))
    else $error("write cycle without acked data");
  a_protect_nack: assert property (@(posedge core_clk) disable iff (!rstn) // see R10
    (st.state == ST_WDATA && st.protect && st.ackPhase) |-> sdaOen)
    else $error("protected data acked");
  a_mismatch_idle: assert property (@(posedge core_clk) disable iff (!rstn) // see R7
    (st.state == ST_SELECT && sclFall && !st.ackPhase && st.bitCnt == SEEB_ACK_SLOT
     && !selMatch(st.shift, pins, ceMask)) |=> st.state == ST_IDLE && sdaOen)
    else $error("mismatch not released");
  a_sel_ack: assert property (@(posedge core_clk) disable iff (!rstn) // see R6
    (st.state == ST_SELECT && st.ackPhase) |-> !sdaOen)
    else $error("select byte not acked");
  a_page_wrap: assert property (@(posedge core_clk) disable iff (!rstn) // see R12
    (st.state == ST_WDATA && $changed(st.addr) && !$rose(busy)) |->
      st.addr[SEEB_ADDR_BITS-1:4] == $past(st.addr[SEEB_ADDR_BITS-1:4]))
    else $error("row bits changed in page write");
  a_read_nack: assert property (@(posedge core_clk) disable iff (!rstn) // see R21
    (st.state == ST_RDATA && st.ackPhase && sclFall) |=> st.state == ST_IDLE)
    else $error("read did not end");
  a_read_release: assert property (@(posedge core_clk) disable iff (!rstn) // see R21
    (st.state == ST_RDATA && st.ackPhase) |-> sdaOen)
    else $error("sda held in master ack slot");
endmodule
